// >>> hw/eeprom_buf.v
// two-entry valid/ready buffer with flush
`timescale 1ns/100ps
`default_nettype none
module eeprom_buf #(
  parameter DW = 8
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_flush,
  input wire i_valid,
  output wire o_ready,
  input wire [DW-1:0] i_data,
  output wire o_valid,
  input wire i_ready,
  output wire [DW-1:0] o_data
);
  reg [DW-1:0] slot_q [0:1];
  reg wr_ptr_q;
  reg rd_ptr_q;
  reg [1:0] count_q;
  wire push;
  wire pop;

  // full and empty come straight from the occupancy count
  assign o_ready = (count_q != 2'h2);
  assign o_valid = (count_q != 2'h0);
  assign o_data = slot_q[rd_ptr_q];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  // flush wins over push so a stale byte never survives a restart
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
      slot_q[0] <= {DW{1'b0}};
      slot_q[1] <= {DW{1'b0}};
    end else if (i_flush) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        slot_q[wr_ptr_q] <= i_data;
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push & ~pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop & ~push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hw/eeprom_defines.vh
// constants for the two-wire serial eeprom slave
`ifndef EEPROM_DEFINES_VH
`define EEPROM_DEFINES_VH
`define EE_AW 11
`define EE_DW 8
`define EE_PAGE_AW 4
`define EE_PAGE_NUM_W 7
`define EE_BYTE_BITS 4'h8
`define EE_MACK_SLOT 4'h9
`define EE_TYPE_HI 7
`define EE_TYPE_LO 4
`define EE_PAGE_SEL_HI 3
`define EE_PAGE_SEL_LO 1
`define EE_RW_BIT 0
`define EE_WR_TIME_NS 5000000
`define EE_CLK_PERIOD_NS 40
`define EE_WC_W 17
`define EE_ADDR_RESET 11'h000
`define EE_COPY_IDLE 5'h10
`endif

// >>> hw/eeprom_mem.v
// byte memory with one write port and a registered read port
`timescale 1ns/100ps
`default_nettype none
module eeprom_mem #(
  parameter AW = 11,
  parameter DW = 8
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output reg [DW-1:0] o_rdata
);
  reg [DW-1:0] ram [0:(1<<AW)-1];

  // storage keeps no reset, as a real array would
  always @(posedge i_clk) begin
    if (i_we) begin
      ram[i_waddr] <= i_wdata;
    end
  end

  // read data always leaves from a register
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= {DW{1'b0}};
    end else begin
      o_rdata <= ram[i_raddr];
    end
  end
endmodule
`default_nettype wire

// >>> hw/eeprom_slave.v
// two-wire serial eeprom slave: bus engine, address counter, write cycle
// Summary of operation
// - data changes only with clock low; changes while high are start/stop
// - falling data with clock high is a start; start precedes every command
// - rising data with clock high is a stop; after a read it means standby
// - bytes are eight bits; device pulls data low on ninth clock to ack
// - standby after power-up, and after stop once the write cycle ends
// - start, nine clocks, start then stop leaves the device ready again
// - first byte after start is device address; top nibble must match type
// - address bits 3..1 give the three top bits of the array address
// - address bit 0 one means read, zero means write
// - matching type is acked; mismatch releases data and goes standby
// - byte write: address, word address, one data byte, each acked, stop
// - stop after a write starts the timed cycle; nothing acked meanwhile
// - page write takes up to sixteen bytes before the closing stop
// - writes bump only the low four address bits, wrapping inside the page
// - address polling is acked only once the write cycle has finished
// - address counter holds one past last byte touched, kept between uses
// - reads wrap from the last array byte to the first
// - current read: ack address, send byte at counter, master nacks, stop
// - random read: dummy write of word address, repeated start, read
// - each master ack sends the next byte; nack plus stop ends the read
// - input sampled on clock rise, output changed after clock fall
// - array is 128 pages of 16 bytes, 11-bit word address
// - protect input high keeps the whole array from being modified
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_defines.vh"
module eeprom_slave #(
  parameter [31:0] WR_CYCLES = `EE_WR_TIME_NS / `EE_CLK_PERIOD_NS,
  parameter [3:0] DEV_TYPE = 4'h6 // arbitrary type code
) (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_scl,
  input wire i_sda,
  input wire i_wp,
  output reg o_sda_out,
  output reg o_sda_oe,
  output reg o_busy,
  output reg o_standby
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_DEV = 5'h02;
  localparam [4:0] ST_WADR = 5'h04;
  localparam [4:0] ST_WDAT = 5'h08;
  localparam [4:0] ST_TX = 5'h10;

  // true when the address byte names this device type
  function dev_hit;
    input [7:0] addr_byte;
    input [3:0] type_code;
    begin
      dev_hit = (addr_byte[`EE_TYPE_HI:`EE_TYPE_LO] == type_code);
    end
  endfunction

  wire [2:0] pin_raw;
  reg [2:0] meta_q, sync_q, prev_q;
  wire scl_s, sda_s, wp_s, scl_rise, scl_fall, start_det, stop_det;
  reg [4:0] state_q, nxt_q, cp_q;
  reg [3:0] bitcnt_q;
  reg [7:0] shift_q;
  reg ack_q, wr_pend_q, fetch_req_q, fetch_rd_q, need_load_q, cp_v_q;
  reg [2:0] page_q;
  reg [`EE_AW-1:0] addr_q;
  reg [15:0] mask_q;
  reg [`EE_PAGE_NUM_W-1:0] wr_page_q;
  reg [`EE_WC_W-1:0] wc_cnt_q;
  reg [3:0] cp_idx_q;
  wire wc_go, byte_done, stage_we, arr_we, pop, buf_in_ready, buf_out_valid;
  wire [7:0] stage_rdata, arr_rdata, buf_out_data;

  // every pin passes two flops before any logic looks at it
  assign pin_raw = {i_wp, i_sda, i_scl};
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
          prev_q[g] <= 1'b1;
        end else begin
          meta_q[g] <= pin_raw[g];
          sync_q[g] <= meta_q[g];
          prev_q[g] <= sync_q[g];
        end
      end
    end
  endgenerate

  assign scl_s = sync_q[0];
  assign sda_s = sync_q[1];
  assign wp_s = sync_q[2];
  assign scl_rise = scl_s & ~prev_q[0];
  assign scl_fall = ~scl_s & prev_q[0];
  // data moving under a high clock
  assign start_det = scl_s & prev_q[0] & prev_q[1] & ~sda_s;
  assign stop_det = scl_s & prev_q[0] & ~prev_q[1] & sda_s;

  assign byte_done = scl_fall & ~ack_q & (bitcnt_q == `EE_BYTE_BITS) &
    ~start_det & ~stop_det;
  // data byte lands in the page latch
  assign stage_we = byte_done & (state_q == ST_WDAT);
  assign wc_go = stop_det & wr_pend_q & ~wp_s & ~o_busy;
  assign pop = need_load_q & buf_out_valid;
  assign arr_we = cp_v_q & mask_q[cp_idx_q];

  // page latch holds the bytes until the stop commits them
  eeprom_mem #(.AW(`EE_PAGE_AW), .DW(`EE_DW)) u_page (
    .i_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_we(stage_we),
    .i_waddr(addr_q[3:0]),
    .i_wdata(shift_q),
    .i_raddr(cp_q[3:0]),
    .o_rdata(stage_rdata)
  );

  eeprom_mem #(.AW(`EE_AW), .DW(`EE_DW)) u_array (
    .i_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_we(arr_we),
    .i_waddr({wr_page_q, cp_idx_q}),
    .i_wdata(stage_rdata),
    .i_raddr(addr_q),
    .o_rdata(arr_rdata)
  );

  // read bytes wait here so a late load never loses one
  eeprom_buf #(.DW(`EE_DW)) u_rdbuf (
    .i_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_flush(start_det | stop_det),
    .i_valid(fetch_rd_q),
    .o_ready(buf_in_ready),
    .i_data(arr_rdata),
    .o_valid(buf_out_valid),
    .i_ready(need_load_q),
    .o_data(buf_out_data)
  );

  // bus engine: start/stop first, then clock edges
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      nxt_q <= ST_IDLE;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      ack_q <= 1'b0;
      page_q <= 3'h0;
      addr_q <= `EE_ADDR_RESET;
      mask_q <= 16'h0000;
      wr_pend_q <= 1'b0;
      wr_page_q <= 7'h00;
      fetch_req_q <= 1'b0;
      fetch_rd_q <= 1'b0;
      need_load_q <= 1'b0;
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
    end else begin
      fetch_rd_q <= 1'b0;
      // counter moves past each byte fetched
      if (fetch_req_q && buf_in_ready) begin
        fetch_req_q <= 1'b0;
        fetch_rd_q <= 1'b1;
        addr_q <= addr_q + 11'h001;
      end
      if (pop) begin
        need_load_q <= 1'b0;
        shift_q <= buf_out_data;
      end
      if (start_det) begin
        // any half-done transfer is dropped here
        state_q <= ST_DEV;
        bitcnt_q <= 4'h0;
        ack_q <= 1'b0;
        o_sda_oe <= 1'b0;
        fetch_req_q <= 1'b0;
        fetch_rd_q <= 1'b0;
        need_load_q <= 1'b0;
        if (!o_busy) begin
          mask_q <= 16'h0000;
          wr_pend_q <= 1'b0;
        end
      end else if (stop_det) begin
        // stop releases the bus and idles
        state_q <= ST_IDLE;
        ack_q <= 1'b0;
        o_sda_oe <= 1'b0;
        fetch_req_q <= 1'b0;
        need_load_q <= 1'b0;
        wr_pend_q <= 1'b0;
      end else if (scl_rise) begin
        if (!ack_q && state_q != ST_TX && state_q != ST_IDLE &&
            bitcnt_q != `EE_BYTE_BITS) begin
          shift_q <= {shift_q[6:0], sda_s};
          bitcnt_q <= bitcnt_q + 4'h1;
        end else if (state_q == ST_TX && bitcnt_q == `EE_MACK_SLOT) begin
          // master ack asks for the next byte
          if (!sda_s) begin
            fetch_req_q <= 1'b1;
            need_load_q <= 1'b1;
            bitcnt_q <= 4'h0;
          end else begin
            state_q <= ST_IDLE;
          end
        end
      end else if (scl_fall) begin
        if (ack_q) begin
          // ack clock over: release or start driving read data
          ack_q <= 1'b0;
          state_q <= nxt_q;
          if (nxt_q == ST_TX) begin
            o_sda_oe <= ~shift_q[7];
            shift_q <= {shift_q[6:0], 1'b0};
            bitcnt_q <= 4'h1;
          end else begin
            o_sda_oe <= 1'b0;
            bitcnt_q <= 4'h0;
          end
        end else begin
          case (state_q)
            ST_DEV: begin
              if (bitcnt_q == `EE_BYTE_BITS) begin
                if (dev_hit(shift_q, DEV_TYPE) && !o_busy) begin
                  // pull data low for the ack
                  ack_q <= 1'b1;
                  o_sda_oe <= 1'b1;
                  // page bits kept for word address
                  page_q <= shift_q[`EE_PAGE_SEL_HI:`EE_PAGE_SEL_LO];
                  if (shift_q[`EE_RW_BIT]) begin
                    nxt_q <= ST_TX;
                    fetch_req_q <= 1'b1;
                    need_load_q <= 1'b1;
                  end else begin
                    nxt_q <= ST_WADR;
                  end
                end else begin
                  state_q <= ST_IDLE;
                end
              end
            end
            ST_WADR: begin
              if (bitcnt_q == `EE_BYTE_BITS) begin
                addr_q <= {page_q, shift_q};
                ack_q <= 1'b1;
                o_sda_oe <= 1'b1;
                nxt_q <= ST_WDAT;
              end
            end
            ST_WDAT: begin
              if (bitcnt_q == `EE_BYTE_BITS) begin
                // low nibble only, wraps inside page
                addr_q <= {addr_q[10:4], addr_q[3:0] + 4'h1};
                mask_q[addr_q[3:0]] <= 1'b1;
                wr_page_q <= addr_q[10:4];
                wr_pend_q <= 1'b1;
                ack_q <= 1'b1;
                o_sda_oe <= 1'b1;
                nxt_q <= ST_WDAT;
              end
            end
            ST_TX: begin
              // next bit goes out after the fall
              if (bitcnt_q < `EE_BYTE_BITS) begin
                o_sda_oe <= ~shift_q[7];
                shift_q <= {shift_q[6:0], 1'b0};
                bitcnt_q <= bitcnt_q + 4'h1;
              end else if (bitcnt_q == `EE_BYTE_BITS) begin
                o_sda_oe <= 1'b0;
                bitcnt_q <= `EE_MACK_SLOT;
              end
            end
            default: begin
              o_sda_oe <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // timed write cycle; the copy takes 17 cycles, far inside the wait
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
      wc_cnt_q <= {`EE_WC_W{1'b0}};
      cp_q <= `EE_COPY_IDLE;
      cp_v_q <= 1'b0;
      cp_idx_q <= 4'h0;
    end else begin
      cp_v_q <= o_busy & ~cp_q[4];
      cp_idx_q <= cp_q[3:0];
      if (wc_go) begin
        o_busy <= 1'b1;
        wc_cnt_q <= WR_CYCLES[`EE_WC_W-1:0];
        cp_q <= 5'h00;
      end else if (o_busy) begin
        wc_cnt_q <= wc_cnt_q - 17'h0_0001;
        if (wc_cnt_q == 17'h0_0001) begin
          o_busy <= 1'b0;
        end
        if (!cp_q[4]) begin
          cp_q <= cp_q + 5'h01;
        end
      end
    end
  end

  // standby when idle and no cycle pending
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_standby <= 1'b1;
    end else begin
      o_standby <= (state_q == ST_IDLE) & ~o_busy & ~wc_go;
    end
  end
endmodule
`default_nettype wire

// >>> verif/eeprom_bus_master.sv
// bus master model driving clock and data of the two-wire link
`timescale 1ns/100ps
`default_nettype none
module eeprom_bus_master (
  input wire logic i_sys_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // released bus idles high, clock stands still between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // quarter of the 320 ns link period, launched just after an edge
  task automatic step();
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic start();
    step();
    o_sda = 1'b1;
    step();
    o_scl = 1'b1;
    step();
    o_sda = 1'b0;
    step();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    step();
    o_sda = 1'b0;
    step();
    o_scl = 1'b1;
    step();
    o_sda = 1'b1;
    step();
  endtask
  // data only moves while clock low
  task automatic bit_io(input logic b, output logic r);
    step();
    o_sda = b;
    step();
    o_scl = 1'b1;
    step();
    step();
    r = i_sda;
    o_scl = 1'b0;
  endtask
  // eight bits msb first, then the ack slot
  task automatic xfer(input logic [7:0] tx, input logic nack,
                      output logic [7:0] rx, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(nack, a);
    ack = !a;
  endtask
  task automatic recover();
    logic r;
    start();
    repeat (9) bit_io(1'b1, r);
    start();
    stop();
  endtask
endmodule
`default_nettype wire

// >>> verif/eeprom_slave_assertions.sv
// concurrent checks on the eeprom slave ports
`timescale 1ns/100ps
`default_nettype none
module eeprom_slave_checker #(
  parameter [31:0] WR_CYCLES = 32'd125000
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_wp,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_busy,
  input wire logic o_standby
);
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [5:0] stop_q;
  logic [31:0] cnt_q;
  wire stop_w = scl_q[1] & sda_q[1] & ~sda_q[2];
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // preloaded high like the design, so release shows no false stop
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      stop_q <= 6'h00;
      cnt_q <= 32'h0000_0000;
    end else begin
      scl_q <= {scl_q[1:0], i_scl};
      sda_q <= {sda_q[1:0], i_sda};
      stop_q <= {stop_q[4:0], stop_w};
      cnt_q <= o_busy ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  // write cycle steps
  sequence s_busy_start;
    $rose(o_busy);
  endsequence
  sequence s_busy_hold;
    o_busy [*8];
  endsequence
  AST_DRIVE_LOW: assert property (o_sda_oe |-> !o_sda_out)
    else $error("data pin driven high");
  AST_OE_SCL_LOW: assert property (
    $changed(o_sda_oe) |-> !(scl_q[1] && scl_q[2]))
    else $error("data output moved with clock high");
  AST_STANDBY_QUIET: assert property (o_standby |-> !o_sda_oe)
    else $error("data driven in standby");
  AST_BUSY_NO_STANDBY: assert property (o_busy |=> !o_standby)
    else $error("standby during write cycle");
  AST_NO_ACK_BUSY: assert property (o_busy |-> !o_sda_oe)
    else $error("ack during write cycle");
  AST_BUSY_HOLDS: assert property (s_busy_start |-> s_busy_hold)
    else $error("write cycle too short");
  AST_BUSY_LENGTH: assert property ($fell(o_busy) |->
    cnt_q >= WR_CYCLES - 2 && cnt_q <= WR_CYCLES + 1)
    else $error("write cycle length wrong");
  AST_BUSY_AFTER_STOP: assert property (
    s_busy_start |-> (stop_w || stop_q != 6'h00))
    else $error("write cycle without stop");
  AST_BUSY_UNPROTECTED: assert property (s_busy_start |-> !i_wp)
    else $error("write cycle while protected");
endmodule
bind eeprom_slave eeprom_slave_checker #(.WR_CYCLES(WR_CYCLES)) u_checker (
  .i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n),
  .i_scl(i_scl),
  .i_sda(i_sda),
  .i_wp(i_wp),
  .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe),
  .o_busy(o_busy),
  .o_standby(o_standby)
);
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the two-wire eeprom slave
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("unexpected %0t got %h exp %h", $time, g, e); \
    end \
  end
module testbench;
  localparam int WR_CYC = 160;
  localparam logic [3:0] TYPE = 4'h6; // arbitrary type code
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp = 1'b0;
  int fail_count = 0;
  int num_checks = 0;
  logic [7:0] exp_mem [0:2047];
  logic [7:0] rx;
  logic ak;
  wire scl;
  wire sda_m;
  wire oe;
  wire busy;
  wire stby;
  wire sda_out;
  // wired-and with pull-up: released data reads high
  wire sda = sda_m & ~oe;
  always #20 clk = ~clk;
  eeprom_slave #(.WR_CYCLES(WR_CYC), .DEV_TYPE(TYPE)) DUT (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
    .i_wp(wp), .o_sda_out(sda_out), .o_sda_oe(oe), .o_busy(busy),
    .o_standby(stby));
  eeprom_bus_master m (.i_sys_clk(clk), .i_sda(sda), .o_scl(scl),
    .o_sda(sda_m));
  // one byte from the master, ack compared
  task automatic send(input logic [7:0] b, input logic ea);
    m.xfer(b, 1'b1, rx, ak);
    `CHK(ak, ea)
  endtask
  task automatic addr(input logic [10:0] a, input logic r, input logic ea);
    m.start();
    send({TYPE, a[10:8], r}, ea);
  endtask
  // write run, mirrored into the expected array unless protected
  task automatic wr(input logic [10:0] a, input int n, input logic [7:0] d);
    addr(a, 1'b0, 1'b1);
    send(a[7:0], 1'b1);
    for (int i = 0; i < n; i++) begin
      send(d + 8'(i), 1'b1);
      if (!wp) exp_mem[{a[10:4], a[3:0] + 4'(i)}] = d + 8'(i);
    end
    m.stop();
  endtask
  // busy rises a few clocks after stop, so look only after that
  task automatic wait_done();
    int k;
    k = 0;
    repeat (4) @(posedge clk);
    #1;
    while (busy !== 1'b0 && k < 400) begin
      @(posedge clk);
      #1;
      k++;
    end
    `CHK(busy, 1'b0)
    // standby follows one clock after the cycle ends
    @(posedge clk);
    #1;
    `CHK(stby, 1'b1)
  endtask
  // dummy write of word address, repeated start, sequential read
  task automatic rd(input logic [10:0] a, input int n);
    addr(a, 1'b0, 1'b1);
    send(a[7:0], 1'b1);
    addr(a, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'hFF, i == n - 1, rx, ak);
      `CHK(rx, exp_mem[a + 11'(i)])
    end
    m.stop();
    // stop after a read drops back to standby
    repeat (3) @(posedge clk);
    #1;
    `CHK(stby, 1'b1)
  endtask
  task automatic t_write_poll();
    wr(11'h123, 1, 8'h5C);
    repeat (3) @(posedge clk);
    #1;
    `CHK(busy, 1'b1)
    addr(11'h123, 1'b0, 1'b0);
    m.stop();
    wait_done();
    rd(11'h123, 1);
  endtask
  // seventeen bytes from offset e overwrite the first one
  task automatic t_page();
    wr(11'h5AE, 17, 8'hA0);
    wait_done();
    rd(11'h5A0, 15);
    m.start();
    send({TYPE, 3'h0, 1'b1}, 1'b1);
    m.xfer(8'hFF, 1'b1, rx, ak);
    `CHK(rx, exp_mem[11'h5AF])
    m.stop();
  endtask
  task automatic t_bad_type();
    m.start();
    send({~TYPE, 4'h0}, 1'b0);
    m.stop();
  endtask
  task automatic t_end_wrap();
    wr(11'h7FF, 2, 8'h11);
    wait_done();
    wr(11'h000, 1, 8'h77);
    wait_done();
    rd(11'h7FF, 2);
    rd(11'h7F0, 1);
  endtask
  task automatic t_protect();
    wp = 1'b1;
    wr(11'h5A3, 1, 8'h33);
    repeat (8) @(posedge clk);
    #1;
    `CHK(busy, 1'b0)
    wp = 1'b0;
    rd(11'h5A3, 1);
  endtask
  // abort mid address, recover, then a normal read
  task automatic t_recover();
    logic r;
    m.start();
    m.bit_io(1'b0, r);
    m.bit_io(1'b1, r);
    m.recover();
    rd(11'h123, 1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    `CHK(stby, 1'b1)
    `CHK(sda_out, 1'b0)
    t_write_poll();
    t_page();
    t_bad_type();
    t_end_wrap();
    t_protect();
    t_recover();
    report_and_stop();
  end
  // whole run needs well under half this span
  initial begin
    #2_000_000;
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
